// ### wer_params.svh
// Constants for the wake exit and reset control block.
// Assumes a 125 MHz system clock; included by wer_top.sv only.
`ifndef WER_PARAMS_SVH
`define WER_PARAMS_SVH

// ==========================================================================
// Clock and delay times
`define WER_CLK_NS 8
`define WER_CPU_READY_NS 1000
`define WER_OST_NS 16000
`define WER_PLL_NS 8000
`define WER_SETTLE_NS 1000
`define WER_FILTER_NS 200
`define WER_POR_NS 1000
`define WER_CNT_W 12

// ==========================================================================
// Register byte offsets
`define WER_ADDR_CTRL 8'h00
`define WER_ADDR_CMD 8'h04
`define WER_ADDR_STATUS 8'h08
`define WER_ADDR_RESET_CTRL 8'h0c
`define WER_ADDR_IRQ_STAT 8'h10
`define WER_ADDR_IRQ_MASK 8'h14

// ==========================================================================
// Field positions and reset values
`define WER_CMD_SLEEP 0
`define WER_CMD_IDLE 1
`define WER_POR_FLAG_BIT 1
`define WER_IRQ_W 4
`define WER_IRQ_WAKE 0
`define WER_IRQ_PRI_RDY 1
`define WER_IRQ_IOSC 2
`define WER_IRQ_PIN_RST 3
`define WER_CTRL_RESET 4'h0

`endif

// ### wer_pin_drv.sv
// Far-side model of the board driving the external reset pin.
// Assumes a pull-up holds the pin high whenever no pulse is commanded.
`timescale 1ns/1ns

module wer_pin_drv (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [7:0] low_len_in,
  output logic pin_out
);
  // ==========================================================
  // Pulse counter
  logic [7:0] cnt_q = 8'h00;

  // The line returns to the pull-up level as soon as the pulse ends.
  assign pin_out = (cnt_q == 8'h00);

  always_ff @(posedge clk_in) begin
    if (go_in) begin
      cnt_q <= low_len_in;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// ### wer_pkg.sv
// Types shared by the wake exit and reset control block.
// Assumes nothing of its surroundings.
package wer_pkg;

  // ========================================================================
  // Oscillator modes and clock sources
  typedef enum logic [2:0] {
    WER_LP    = 3'h0,
    WER_XT    = 3'h1,
    WER_HS    = 3'h2,
    WER_HIGH_SPEED_PLL_MODE = 3'h3,
    WER_RC    = 3'h4,
    WER_EC    = 3'h5,
    WER_INTERNAL_OSC_IO_MODE = 3'h6
  } wer_osc_mode_t;

  typedef enum logic [1:0] {
    WER_SRC_PRIMARY   = 2'h0,
    WER_SRC_SECONDARY = 2'h1,
    WER_SRC_SLOW      = 2'h2,
    WER_SRC_FAST      = 2'h3
  } wer_clk_src_t;

  // ========================================================================
  // Power state, Gray coded along run, sleep, wake
  typedef enum logic [1:0] {
    WER_RUN   = 2'h0,
    WER_SLEEP = 2'h1,
    WER_WAKE  = 2'h3,
    WER_IDLE  = 2'h2
  } wer_state_t;

  typedef struct packed {
    wer_clk_src_t idle_src;
    logic sec_en;
    logic alt_en;
  } wer_ctrl_t;

endpackage

// ### wer_top.sv
// Wake exit sequencer and reset control with an AHB-Lite register slave.
// Assumes pins and the AHB-Lite bus are synchronous to sys_clk_in.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "wer_params.svh"

module wer_top #(
  parameter int CPU_READY_NS = `WER_CPU_READY_NS,
  parameter int OST_NS = `WER_OST_NS,
  parameter int PLL_NS = `WER_PLL_NS,
  parameter int SETTLE_NS = `WER_SETTLE_NS,
  parameter int FILTER_NS = `WER_FILTER_NS,
  parameter int POR_NS = `WER_POR_NS
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [3:0] oscillator_select_bits_in,
  input wire logic external_reset_pin_enable_in,
  input wire logic external_reset_pin_in,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe_out,
  output logic reset_pin_data_out,
  input wire logic wake_event_in,
  output logic sys_reset_n_out,
  output logic cpu_run_out,
  output logic [1:0] clk_src_out,
  output logic pri_osc_en_out,
  output logic fast_osc_en_out,
  output logic sec_osc_en_out,
  output logic slow_osc_en_out,
  output logic irq_out
);

  // ========================================================================
  // Delay counts
  localparam int CW = `WER_CNT_W;
  localparam int CPU_CYC = (CPU_READY_NS + `WER_CLK_NS - 1) / `WER_CLK_NS;
  localparam int OST_CYC = (OST_NS + `WER_CLK_NS - 1) / `WER_CLK_NS;
  localparam int PLL_CYC = (PLL_NS + `WER_CLK_NS - 1) / `WER_CLK_NS;
  localparam int SET_CYC = (SETTLE_NS + `WER_CLK_NS - 1) / `WER_CLK_NS;
  localparam int FLT_CYC = (FILTER_NS + `WER_CLK_NS - 1) / `WER_CLK_NS;
  localparam int POR_CYC = (POR_NS + `WER_CLK_NS - 1) / `WER_CLK_NS;
  localparam logic [CW-1:0] CPU_CNT = CW'(CPU_CYC);
  localparam logic [CW-1:0] OST_CNT = CW'(OST_CYC);
  localparam logic [CW-1:0] PLL_CNT = CW'(PLL_CYC);
  localparam logic [CW-1:0] SET_CNT = CW'(SET_CYC);
  localparam logic [CW-1:0] FLT_CNT = CW'(FLT_CYC);
  localparam logic [CW-1:0] POR_CNT = CW'(POR_CYC);
  localparam logic [CW-1:0] ONE = CW'(1);

  if (CPU_CYC < 1 || OST_CYC < 1 || PLL_CYC < 1 || SET_CYC < 1 ||
      FLT_CYC < 1 || POR_CYC < 1 || OST_CYC + PLL_CYC >= (1 << CW) ||
      CPU_CYC >= (1 << CW) || SET_CYC >= (1 << CW) ||
      FLT_CYC >= (1 << CW) || POR_CYC >= (1 << CW)) begin : g_bad_cnt
    $error("wer_top: a delay count does not fit the counters");
  end

  // ========================================================================
  // Decoding helpers
  // Encodings 4'ha to 4'hf are taken as RC so that no value is illegal.
  function automatic wer_pkg::wer_osc_mode_t osc_decode(
      input logic [3:0] sel);
    case (sel)
      4'h0: osc_decode = wer_pkg::WER_LP;
      4'h1: osc_decode = wer_pkg::WER_XT;
      4'h2: osc_decode = wer_pkg::WER_HS;
      4'h4, 4'h5: osc_decode = wer_pkg::WER_EC;
      4'h6: osc_decode = wer_pkg::WER_HIGH_SPEED_PLL_MODE;
      4'h8, 4'h9: osc_decode = wer_pkg::WER_INTERNAL_OSC_IO_MODE;
      default: osc_decode = wer_pkg::WER_RC;
    endcase
  endfunction

  function automatic logic is_crystal(input wer_pkg::wer_osc_mode_t m);
    is_crystal = (m == wer_pkg::WER_LP) || (m == wer_pkg::WER_XT) ||
                 (m == wer_pkg::WER_HS) || (m == wer_pkg::WER_HIGH_SPEED_PLL_MODE);
  endfunction

  // ========================================================================
  // Power-on pulse, strap capture and reset pin filter
  logic [CW-1:0] por_cnt_q;
  logic por_busy;
  logic [3:0] osc_sel_q;
  logic pin_en_q;
  logic [CW-1:0] flt_cnt_q;
  logic pin_rst_q;
  logic pin_low;
  logic soft_rst;
  wer_pkg::wer_osc_mode_t mode;

  assign por_busy = (por_cnt_q != '0);
  assign mode = osc_decode(osc_sel_q);
  assign pin_low = pin_en_q & ~external_reset_pin_in;
  assign soft_rst = por_busy | pin_rst_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_cnt_q <= POR_CNT;
    end else if (por_busy) begin
      por_cnt_q <= por_cnt_q - ONE;
    end
  end

  // Configuration is nonvolatile, so it is sampled only while the
  // power-on pulse stands and then held.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_sel_q <= 4'h0;
      pin_en_q <= 1'b0;
    end else if (por_busy) begin
      osc_sel_q <= oscillator_select_bits_in;
      pin_en_q <= external_reset_pin_enable_in;
    end
  end

  // A low shorter than the filter time never reaches the reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flt_cnt_q <= '0;
      pin_rst_q <= 1'b0;
    end else if (!pin_low) begin
      flt_cnt_q <= '0;
      pin_rst_q <= 1'b0;
    end else if (flt_cnt_q == FLT_CNT) begin
      pin_rst_q <= 1'b1;
    end else begin
      flt_cnt_q <= flt_cnt_q + ONE;
    end
  end

  // ========================================================================
  // AHB-Lite slave, zero wait states
  logic ahb_go;
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic rd_irq_clr;
  wer_pkg::wer_ctrl_t ctrl_q;
  logic por_flag_q;
  logic [`WER_IRQ_W-1:0] irq_q;
  logic [`WER_IRQ_W-1:0] mask_q;
  logic [`WER_IRQ_W-1:0] irq_ev;
  wer_pkg::wer_state_t st_q;
  logic pri_ready_q;
  logic iosc_ok_q;
  logic cpu_run_q;

  assign ahb_go = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'h2);
  assign rd_irq_clr = ahb_go & ~hwrite_in &
                      (haddr_in[7:0] == `WER_ADDR_IRQ_STAT);

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = 32'h0;
    case (a)
      `WER_ADDR_CTRL: rd_mux[3:0] = ctrl_q;
      `WER_ADDR_STATUS: rd_mux[10:0] = {external_reset_pin_in, pin_en_q,
        osc_sel_q, cpu_run_q, st_q, iosc_ok_q, pri_ready_q};
      `WER_ADDR_RESET_CTRL: rd_mux[`WER_POR_FLAG_BIT] = por_flag_q;
      `WER_ADDR_IRQ_STAT: rd_mux[`WER_IRQ_W-1:0] = irq_q;
      `WER_ADDR_IRQ_MASK: rd_mux[`WER_IRQ_W-1:0] = mask_q;
      default: rd_mux = 32'h0;
    endcase
  endfunction

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h0;
      hrdata_q <= 32'h0;
    end else begin
      wr_q <= ahb_go & hwrite_in;
      if (ahb_go) begin
        waddr_q <= haddr_in[7:0];
      end
      if (ahb_go & ~hwrite_in) begin
        hrdata_q <= rd_mux(haddr_in[7:0]);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end
  assign hrdata_out = hrdata_q;
  assign cpu_run_out = cpu_run_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `WER_CTRL_RESET;
      mask_q <= '0;
    end else if (soft_rst) begin
      ctrl_q <= `WER_CTRL_RESET;
    end else if (wr_q && waddr_q == `WER_ADDR_CTRL) begin
      ctrl_q <= hwdata_in[3:0];
    end else if (wr_q && waddr_q == `WER_ADDR_IRQ_MASK) begin
      mask_q <= hwdata_in[`WER_IRQ_W-1:0];
    end
  end

  // The flag survives pin resets; only the power-on reset or a write of 0 to bit 1 clears it.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_flag_q <= 1'b0;
    end else if (wr_q && waddr_q == `WER_ADDR_RESET_CTRL) begin
      por_flag_q <= hwdata_in[`WER_POR_FLAG_BIT];
    end
  end

  // A new event wins over the clear by a read in the same cycle.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_q <= (irq_q & ~{`WER_IRQ_W{rd_irq_clr}}) | irq_ev;
      irq_out <= |(irq_q & mask_q);
    end
  end

  // ========================================================================
  // Wake sequencer
  logic pm_go;
  logic go_sleep;
  logic wake_go;
  logic pri_off_q;
  logic fast_off_q;
  logic need_ost;
  logic need_set;
  logic wake_done;
  logic [CW-1:0] cpu_cnt_q;
  logic [CW-1:0] ost_cnt_q;
  logic [CW-1:0] set_cnt_q;
  logic pin_rst_d1_q;

  assign pm_go = (st_q == wer_pkg::WER_RUN) & wr_q & ctrl_q.alt_en &
    (waddr_q == `WER_ADDR_CMD) &
    (hwdata_in[`WER_CMD_SLEEP] | hwdata_in[`WER_CMD_IDLE]);
  assign go_sleep = hwdata_in[`WER_CMD_SLEEP];
  assign wake_go = wake_event_in & ((st_q == wer_pkg::WER_SLEEP) |
                                    (st_q == wer_pkg::WER_IDLE));
  assign need_ost = pri_off_q & is_crystal(mode);
  // The fast source here means the 8 MHz block at any postscaler rate.
  assign need_set = fast_off_q & (mode == wer_pkg::WER_INTERNAL_OSC_IO_MODE);
  assign wake_done = (st_q == wer_pkg::WER_WAKE) && (cpu_cnt_q <= ONE) &&
                     (ost_cnt_q <= ONE);
  assign irq_ev = {pin_rst_q & ~pin_rst_d1_q,
                   set_cnt_q == ONE, ost_cnt_q == ONE, wake_done};

  // Which oscillators stop is fixed when the mode is entered.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pri_off_q <= 1'b0;
      fast_off_q <= 1'b0;
    end else if (soft_rst) begin
      pri_off_q <= 1'b0;
      fast_off_q <= 1'b0;
    end else if (pm_go) begin
      pri_off_q <= go_sleep |
                   (ctrl_q.idle_src != wer_pkg::WER_SRC_PRIMARY);
      fast_off_q <= go_sleep | !((ctrl_q.idle_src == wer_pkg::WER_SRC_FAST)
        | ((ctrl_q.idle_src == wer_pkg::WER_SRC_PRIMARY) &
           (mode == wer_pkg::WER_INTERNAL_OSC_IO_MODE)));
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= wer_pkg::WER_RUN;
      cpu_run_q <= 1'b0;
    end else if (soft_rst) begin
      st_q <= wer_pkg::WER_RUN;
      cpu_run_q <= 1'b0;
    end else begin
      unique case (st_q)
        wer_pkg::WER_RUN: begin
          cpu_run_q <= !pm_go;
          if (pm_go) begin
            st_q <= go_sleep ? wer_pkg::WER_SLEEP : wer_pkg::WER_IDLE;
          end
        end
        wer_pkg::WER_SLEEP, wer_pkg::WER_IDLE: begin
          if (wake_go) begin
            st_q <= wer_pkg::WER_WAKE;
          end
        end
        wer_pkg::WER_WAKE: begin
          if (wake_done) begin
            st_q <= wer_pkg::WER_RUN;
            cpu_run_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // The CPU-ready, start-up and settling counters load on the same edge.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_cnt_q <= '0;
      ost_cnt_q <= '0;
      set_cnt_q <= '0;
    end else if (soft_rst) begin
      cpu_cnt_q <= '0;
      ost_cnt_q <= '0;
      set_cnt_q <= '0;
    end else if (wake_go) begin
      cpu_cnt_q <= CPU_CNT;
      ost_cnt_q <= !need_ost ? '0 :
        (mode == wer_pkg::WER_HIGH_SPEED_PLL_MODE ? OST_CNT + PLL_CNT : OST_CNT);
      set_cnt_q <= need_set ? SET_CNT : '0;
    end else begin
      if (cpu_cnt_q != '0) cpu_cnt_q <= cpu_cnt_q - ONE;
      if (ost_cnt_q != '0) ost_cnt_q <= ost_cnt_q - ONE;
      if (set_cnt_q != '0) set_cnt_q <= set_cnt_q - ONE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pri_ready_q <= 1'b1;
      iosc_ok_q <= 1'b1;
    end else if (soft_rst) begin
      pri_ready_q <= 1'b1;
      iosc_ok_q <= 1'b1;
    end else begin
      if (wake_go && need_ost) pri_ready_q <= 1'b0;
      else if (ost_cnt_q == ONE) pri_ready_q <= 1'b1;
      if (wake_go && need_set) iosc_ok_q <= 1'b0;
      else if (set_cnt_q == ONE) iosc_ok_q <= 1'b1;
    end
  end

  // ========================================================================
  // Registered pin, reset and clock outputs
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      external_reset_pin_out <= 1'b0;
      external_reset_pin_oe_out <= 1'b0;
      reset_pin_data_out <= 1'b0;
      sys_reset_n_out <= 1'b0;
      pin_rst_d1_q <= 1'b0;
    end else begin
      external_reset_pin_out <= 1'b0;
      external_reset_pin_oe_out <= 1'b0;
      reset_pin_data_out <= ~pin_en_q & external_reset_pin_in;
      sys_reset_n_out <= ~soft_rst;
      pin_rst_d1_q <= pin_rst_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_src_out <= 2'h0;
      pri_osc_en_out <= 1'b1;
      fast_osc_en_out <= 1'b0;
      sec_osc_en_out <= 1'b0;
      slow_osc_en_out <= 1'b1;
    end else begin
      clk_src_out <= (st_q == wer_pkg::WER_IDLE) ? ctrl_q.idle_src :
        ((mode == wer_pkg::WER_INTERNAL_OSC_IO_MODE) ? wer_pkg::WER_SRC_FAST :
         wer_pkg::WER_SRC_PRIMARY);
      pri_osc_en_out <= !(pri_off_q && (st_q == wer_pkg::WER_SLEEP ||
                                         st_q == wer_pkg::WER_IDLE));
      fast_osc_en_out <= !(fast_off_q && (st_q == wer_pkg::WER_SLEEP ||
        st_q == wer_pkg::WER_IDLE)) && (mode == wer_pkg::WER_INTERNAL_OSC_IO_MODE ||
        ctrl_q.idle_src == wer_pkg::WER_SRC_FAST);
      sec_osc_en_out <= ctrl_q.sec_en;
      slow_osc_en_out <= 1'b1;
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_wake_taken;
    wake_go && !soft_rst ##1 st_q == wer_pkg::WER_WAKE;
  endsequence

  property p_pin_not_driven;
    !external_reset_pin_oe_out && !external_reset_pin_out;
  endproperty
  a_pin_not_driven: assert property (p_pin_not_driven)
    else $error("reset pin driven");

  property p_resume;
    wake_done && !soft_rst |=> cpu_run_out && st_q == wer_pkg::WER_RUN;
  endproperty
  a_resume: assert property (p_resume)
    else $error("execution did not resume after delay");

  property p_concurrent;
    st_q == wer_pkg::WER_WAKE && ost_cnt_q > ONE && !soft_rst
      |=> st_q == wer_pkg::WER_WAKE && !cpu_run_out;
  endproperty
  a_concurrent: assert property (p_concurrent)
    else $error("woke before start-up delay ended");

  property p_skip_ost;
    (wake_go && !need_ost && !soft_rst) |=> ost_cnt_q == '0;
  endproperty
  a_skip_ost: assert property (p_skip_ost)
    else $error("start-up timer ran when it should be skipped");

  property p_cpu_delay;
    s_wake_taken |-> cpu_cnt_q == CPU_CNT && !cpu_run_out;
  endproperty
  a_cpu_delay: assert property (p_cpu_delay)
    else $error("CPU-ready delay not loaded");

  property p_pri_flag;
    (ost_cnt_q != '0 |-> !pri_ready_q) and
    (ost_cnt_q == ONE && !soft_rst |=> pri_ready_q);
  endproperty
  a_pri_flag: assert property (p_pri_flag)
    else $error("primary ready flag wrong");

  property p_iosc_run;
    set_cnt_q > ONE && wake_done && !soft_rst |=> cpu_run_out && !iosc_ok_q;
  endproperty
  a_iosc_run: assert property (p_iosc_run)
    else $error("execution held during settling");

  property p_filter;
    !pin_low |=> !pin_rst_q ##1 (sys_reset_n_out || $past(por_busy));
  endproperty
  a_filter: assert property (p_filter)
    else $error("reset without filtered pin low");

  property p_pin_disabled;
    !pin_en_q |-> !pin_rst_q;
  endproperty
  a_pin_disabled: assert property (p_pin_disabled)
    else $error("disabled pin caused reset");

  property p_por_flag;
    !(wr_q && waddr_q == `WER_ADDR_RESET_CTRL) |=> $stable(por_flag_q);
  endproperty
  a_por_flag: assert property (p_por_flag)
    else $error("power-on flag changed without a write");

  property p_alt_needed;
    st_q == wer_pkg::WER_RUN && !ctrl_q.alt_en |=> st_q == wer_pkg::WER_RUN;
  endproperty
  a_alt_needed: assert property (p_alt_needed)
    else $error("power-managed mode without alternate clock");

endmodule

// ### wer_top_tb.sv
// Self-checking bench for the wake exit and reset control block.
// Assumes the design answers AHB-Lite with zero wait states.
`timescale 1ns/1ns

module wer_top_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hwrite = 1'b0;
  logic pin_en = 1'b1;
  logic wake = 1'b0;
  logic go = 1'b0;
  logic seen, dlow;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [2:0] bsz = 3'h2;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd, hrdata;
  logic [3:0] strap = 4'h4;
  logic [7:0] low_len = 8'h00;
  logic hrdy, hresp, pin_o, pin_oe, pin_d, srst_n, run, irq, drv, pin;
  logic pri_en, fast_en, sec_en, slow_en;
  logic [1:0] src;
  int failures = 0;
  int num_checks = 0;
  int n;
  logic [3:0] t_sel [5] = '{4'h4, 4'h2, 4'h2, 4'h6, 4'h8};
  logic [31:0] t_cmd [5] = '{32'h1, 32'h1, 32'h2, 32'h1, 32'h1};
  int t_exp [5] = '{50, 200, 50, 300, 50};

  always #4 clk = ~clk;
  assign pin = pin_oe ? pin_o : drv;

  wer_pin_drv u_drv (.clk_in(clk), .go_in(go), .low_len_in(low_len),
    .pin_out(drv));

  // Times are shortened so that each wake fits in a few hundred cycles.
  wer_top #(.CPU_READY_NS(400), .OST_NS(1600), .PLL_NS(800),
    .SETTLE_NS(400), .FILTER_NS(200), .POR_NS(1000)) DUT (
    .sys_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .oscillator_select_bits_in(strap),
    .external_reset_pin_enable_in(pin_en),
    .external_reset_pin_in(pin), .external_reset_pin_out(pin_o),
    .external_reset_pin_oe_out(pin_oe), .reset_pin_data_out(pin_d),
    .wake_event_in(wake), .sys_reset_n_out(srst_n), .cpu_run_out(run),
    .clk_src_out(src), .pri_osc_en_out(pri_en),
    .fast_osc_en_out(fast_en), .sec_osc_en_out(sec_en),
    .slow_osc_en_out(slow_en), .irq_out(irq));

  // ==========================================================
  // Shared tasks
  task chk(input string s, input logic [31:0] seen_v, input logic [31:0] exp);
    num_checks++;
    if (seen_v !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, exp, seen_v);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= bsz;
    cyc(1);
    while (hrdy !== 1'b1) cyc(1);
    htrans <= 2'h0;
    hwdata <= wd;
    cyc(1);
    while (hrdy !== 1'b1) cyc(1);
    rd = hrdata;
  endtask

  task wait_run();
    n = 0;
    while (run !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk("run_timeout", run, 1'b1);
  endtask

  task por(input logic [3:0] s, input logic e);
    strap <= s;
    pin_en <= e;
    rst_n <= 1'b0;
    cyc(12);
    rst_n <= 1'b1;
    cyc(100);
    chk("por_pulse", srst_n, 1'b0);
    wait_run();
    bus(1'b0, 8'h0c, 32'h0);
    chk("por_flag", rd[1], 1'b0);
    bus(1'b1, 8'h0c, 32'h2);
  endtask

  task pulse(input logic [7:0] len);
    low_len <= len;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    seen = 1'b0;
    dlow = 1'b0;
    repeat (int'(len) + 40) begin
      cyc(1);
      if (srst_n === 1'b0) seen = 1'b1;
      if (pin_d === 1'b0) dlow = 1'b1;
    end
  endtask

  task conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    for (int i = 0; i < 5; i++) begin
      por(t_sel[i], 1'b1);
      bus(1'b1, 8'h04, t_cmd[i]);
      bus(1'b0, 8'h08, 32'h0);
      chk("no_alt", rd[3:2], 2'h0);
      bus(1'b1, 8'h00, 32'h3);
      bus(1'b1, 8'h14, 32'h1);
      bus(1'b0, 8'h10, 32'h0);
      bus(1'b1, 8'h04, t_cmd[i]);
      cyc(2);
      bus(1'b0, 8'h08, 32'h0);
      chk("pm_state", rd[3:2], t_cmd[i][0] ? 2'h1 : 2'h2);
      chk("sec_run", sec_en, 1'b1);
      chk("slow_run", slow_en, 1'b1);
      wake <= 1'b1;
      wait_run();
      wake <= 1'b0;
      chk("wake_delay", n >= t_exp[i] - 2 && n <= t_exp[i] + 2, 1'b1);
      cyc(60);
      bus(1'b0, 8'h08, 32'h0);
      chk("clk_ready", rd[1:0], 2'h3);
      chk("irq_on", irq, 1'b1);
      bus(1'b0, 8'h10, 32'h0);
      chk("irq_wake", rd[0], 1'b1);
      cyc(2);
      chk("irq_off", irq, 1'b0);
      $display("test wake %0d done", i);
    end
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    bsz = 3'h0;
    bus(1'b1, 8'h14, 32'h0);
    bsz = 3'h2;
    hsel <= 1'b0;
    bus(1'b1, 8'h14, 32'h0);
    hsel <= 1'b1;
    bus(1'b0, 8'h14, 32'h0);
    chk("refused_wr", rd, 32'h1);
    pulse(8'd10);
    chk("short_pulse", seen, 1'b0);
    pulse(8'd40);
    chk("long_pulse", seen, 1'b1);
    chk("pin_oe", pin_oe, 1'b0);
    chk("pin_out", pin_o, 1'b0);
    wait_run();
    bus(1'b0, 8'h0c, 32'h0);
    chk("flag_kept", rd[1], 1'b1);
    bus(1'b0, 8'h10, 32'h0);
    chk("irq_pin", rd[3], 1'b1);
    $display("test pin reset done");
    por(4'h4, 1'b0);
    pulse(8'd40);
    chk("pin_off", seen, 1'b0);
    chk("pin_low_read", dlow, 1'b1);
    chk("pin_high_read", pin_d, 1'b1);
    $display("test pin disabled done");
    conclude();
  end

  // A hang is cut short well beyond the few thousand cycles the tests need.
  initial begin
    #320000;
    failures++;
    conclude();
  end
endmodule
